// File: hw/port_host.sv
`timescale 1ns/1ps
`default_nettype none
module port_host (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic req_valid_in,
    input wire port_host_pkg::req_t req_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output port_host_pkg::rsp_t rsp_out,
    output logic select_n_out,
    output logic output_enable_n_out,
    output logic rw_n_out,
    output logic [10:0] addr_out,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    input wire logic [7:0] data_in,
    input wire logic busy_n_in,
    input wire logic mailbox_flag_n_in,
    output logic mailbox_pending_out,
    output logic collision_out
);
    import port_host_pkg::*;

    typedef struct packed {
        state_t st;
        req_t req;
        pins_t pins;
        logic [3:0] cnt;
        logic [2:0] busy_sync;
        logic [2:0] flag_sync;
        logic busy_n;
        logic flag_n;
        logic busy_hit;
        logic ready;
        logic rsp_valid;
        rsp_t rsp;
        logic collision;
        logic pending;
        // set by any backed-off attempt, reported with the response
        logic retried;
    } host_state_t;

    host_state_t s_q, s_d;

    // pin inputs: accept a change once stages two and three agree
    function automatic logic filt(input logic [2:0] sh, input logic cur);
        filt = (sh[1] == sh[2]) ? sh[2] : cur;
    endfunction

    always_comb begin
        s_d = s_q;
        // a deeper array hands its merged busy to this single pin
        s_d.busy_sync = {s_q.busy_sync[1:0], busy_n_in};
        s_d.flag_sync = {s_q.flag_sync[1:0], mailbox_flag_n_in};
        s_d.busy_n = filt(s_q.busy_sync, s_q.busy_n);
        s_d.flag_n = filt(s_q.flag_sync, s_q.flag_n);
        // registered so the output is a plain flip-flop
        s_d.pending = !s_d.flag_n;
        s_d.rsp_valid = 1'b0;
        s_d.collision = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                s_d.pins.select_n = 1'b1;
                s_d.pins.output_enable_n = 1'b1;
                s_d.pins.rw_n = 1'b1;
                s_d.pins.data_oe_n = 1'b1;
                if (req_valid_in && s_q.ready) begin
                    s_d.req = req_in;
                    s_d.ready = 1'b0;
                    s_d.busy_hit = 1'b0;
                    s_d.retried = 1'b0;
                    s_d.pins.addr = req_in.addr;
                    s_d.pins.dout = req_in.wdata;
                    s_d.cnt = SETUP_CNT;
                    s_d.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address settles before select so arbitration sees stable inputs
                s_d.pins.select_n = 1'b0;
                s_d.pins.output_enable_n = (s_q.req.op == OP_WRITE);
                s_d.pins.rw_n = (s_q.req.op != OP_WRITE);
                s_d.pins.data_oe_n = (s_q.req.op != OP_WRITE);
                s_d.cnt = ACCESS_CNT;
                s_d.st = ST_ACCESS;
            end
            ST_ACCESS: begin
                // sticky, so a short busy still forces a retry
                if (!s_q.busy_n) begin
                    s_d.busy_hit = 1'b1;
                end
                if (s_q.cnt != 4'h0) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else if (!s_q.busy_n || s_q.busy_hit) begin
                    // access saw busy from the device, so back off and redo it
                    s_d.collision = 1'b1;
                    s_d.retried = 1'b1;
                    s_d.pins.select_n = 1'b1;
                    s_d.pins.rw_n = 1'b1;
                    s_d.pins.output_enable_n = 1'b1;
                    s_d.pins.data_oe_n = 1'b1;
                    s_d.cnt = RETRY_CNT;
                    s_d.st = ST_BACKOFF;
                end else begin
                    s_d.rsp.rdata = data_in;
                    s_d.rsp.busy_seen = s_q.retried;
                    s_d.pins.select_n = 1'b1;
                    s_d.pins.rw_n = 1'b1;
                    s_d.pins.output_enable_n = 1'b1;
                    s_d.pins.data_oe_n = 1'b1;
                    s_d.st = ST_DONE;
                end
            end
            ST_BACKOFF: begin
                // holding off until busy lifts keeps retries from hammering the winner
                if (s_q.cnt != 4'h0) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else if (s_q.busy_n) begin
                    s_d.busy_hit = 1'b0;
                    s_d.cnt = SETUP_CNT;
                    s_d.st = ST_SETUP;
                end
            end
            ST_DONE: begin
                s_d.rsp_valid = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = ST_IDLE;
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.pins.select_n <= 1'b1;
            s_q.pins.output_enable_n <= 1'b1;
            s_q.pins.rw_n <= 1'b1;
            s_q.pins.data_oe_n <= 1'b1;
            s_q.busy_sync <= 3'h7;
            s_q.flag_sync <= 3'h7;
            s_q.busy_n <= 1'b1;
            s_q.flag_n <= 1'b1;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready_out = s_q.ready;
    assign rsp_valid_out = s_q.rsp_valid;
    assign rsp_out = s_q.rsp;
    assign select_n_out = s_q.pins.select_n;
    assign output_enable_n_out = s_q.pins.output_enable_n;
    assign rw_n_out = s_q.pins.rw_n;
    assign addr_out = s_q.pins.addr;
    assign data_out = s_q.pins.dout;
    assign data_oe_n_out = s_q.pins.data_oe_n;
    // flag is optional for the system; left unread it costs nothing
    assign mailbox_pending_out = s_q.pending;
    assign collision_out = s_q.collision;

    // host-side checks; the device's own behaviour is held by the partner model
    a_idle_deselect: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (s_q.st == ST_IDLE) |-> select_n_out) else $error("select active while idle");
    a_write_lanes: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!rw_n_out) |-> (!select_n_out && !data_oe_n_out && output_enable_n_out))
        else $error("write strobe without select or data drive");
    a_busy_retry: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (s_q.st == ST_ACCESS && s_q.cnt == 4'h0 && s_q.busy_hit) |=> (s_q.st == ST_BACKOFF))
        else $error("busy access not retried");
    a_no_rsp_busy: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (s_q.st == ST_ACCESS && s_q.cnt == 4'h0 && s_q.busy_hit)
        |=> (select_n_out && rw_n_out && !rsp_valid_out))
        else $error("busy access not released before retry");
    a_addr_stable: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!select_n_out && !$rose(select_n_out)) |-> $stable(addr_out) or $fell(select_n_out))
        else $error("address moved during selected access");
    a_clear_uses_oe: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (s_q.st == ST_ACCESS && s_q.req.op == OP_CLEAR) |-> !output_enable_n_out)
        else $error("clear access without output enable");
    a_flag_pending: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $fell(s_q.flag_n) |=> mailbox_pending_out) else $error("flag not reported");
    a_collision_single: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        collision_out |=> !collision_out) else $error("collision flag held past one cycle");
    a_ready_refuse: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (req_valid_in && req_ready_out) |=> !req_ready_out)
        else $error("ready stayed high after a request was taken");
    a_backoff_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (s_q.st == ST_BACKOFF) |-> (select_n_out && rw_n_out && data_oe_n_out))
        else $error("port pins active during backoff");
    a_rsp_ready: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        rsp_valid_out |-> req_ready_out) else $error("response without ready");
    c_write: cover property (@(posedge clk_in) !rw_n_out ##[1:20] rsp_valid_out);
    c_retry: cover property (@(posedge clk_in) collision_out);
    c_flag: cover property (@(posedge clk_in) $rose(mailbox_pending_out));
    c_read: cover property (@(posedge clk_in)
        (!select_n_out && !output_enable_n_out) ##[1:20] rsp_valid_out);
    c_busy_done: cover property (@(posedge clk_in) rsp_valid_out && rsp_out.busy_seen);
endmodule
`default_nettype wire

// File: hw/port_host_pkg.sv
package port_host_pkg;

    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam logic [10:0] MAILBOX_LEFT_ADDR = 11'h7fe;
    localparam logic [10:0] MAILBOX_RIGHT_ADDR = 11'h7ff;

    // cycle counts at 100 MHz; access and backoff count down their counts, setup lasts one cycle and ignores SETUP_CNT
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 20;
    localparam int ACCESS_NS = 60;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
    localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
    localparam logic [3:0] RETRY_CNT = 4'h4;

    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_CLEAR = 2'b10
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic busy_seen;
    } rsp_t;

    typedef struct packed {
        logic select_n;
        logic output_enable_n;
        logic rw_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic data_oe_n;
    } pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ACCESS = 3'b010,
        ST_BACKOFF = 3'b011,
        ST_DONE = 3'b100
    } state_t;

endpackage

// File: verification/dpram_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpram_model (
    input wire logic l_sel_n_in,
    input wire logic l_oe_n_in,
    input wire logic l_rw_n_in,
    input wire logic [10:0] l_addr_in,
    input wire logic [7:0] l_data_in,
    output logic [7:0] l_data_out,
    output logic l_busy_n_out,
    output logic l_flag_n_out = 1'b1,
    input wire logic r_sel_n_in,
    input wire logic r_rw_n_in,
    input wire logic [10:0] r_addr_in,
    input wire logic [7:0] r_data_in,
    output logic r_flag_n_out = 1'b1
);
    logic [7:0] mem [2048];
    logic [7:0] last = 8'h00;
    logic r_first = 1'b0;
    logic l_was_sel = 1'b0;
    logic l_hit;
    logic l_rd, hit;
    assign l_rd = !l_sel_n_in && !l_oe_n_in && l_rw_n_in;
    assign hit = !l_sel_n_in && !r_sel_n_in && l_addr_in == r_addr_in;
    // released bus shows the inverse, so stale data never passes for a read
    assign l_data_out = l_rd ? mem[l_addr_in] : ~last;
    assign l_busy_n_out = !(hit && r_first);
    // winner worked out inside the access process, so no write sees a stale winner
    always @(l_sel_n_in, l_oe_n_in, l_rw_n_in, l_addr_in, l_data_in,
             r_sel_n_in, r_rw_n_in, r_addr_in, r_data_in) begin
        l_hit = !l_sel_n_in && !r_sel_n_in && l_addr_in == r_addr_in;
        if (l_sel_n_in) begin
            l_was_sel = 1'b0;
        end else if (!l_was_sel) begin
            l_was_sel = 1'b1;
            r_first = l_hit;
        end
        if (!l_sel_n_in && !l_oe_n_in && l_rw_n_in)
            last = mem[l_addr_in];
        if (!l_sel_n_in && !l_rw_n_in && !(l_hit && r_first)) begin
            mem[l_addr_in] = l_data_in;
            if (l_addr_in == 11'h7ff)
                r_flag_n_out = 1'b0;
        end
        if (!r_sel_n_in && !r_rw_n_in && !(l_hit && !r_first)) begin
            mem[r_addr_in] = r_data_in;
            if (r_addr_in == 11'h7fe)
                l_flag_n_out = 1'b0;
        end
        if (!l_sel_n_in && !l_oe_n_in && l_addr_in == 11'h7fe)
            l_flag_n_out = 1'b1;
        if (!r_sel_n_in && r_addr_in == 11'h7ff)
            r_flag_n_out = 1'b1;
    end
endmodule
`default_nettype wire

// File: verification/tb_port_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_port_host;
    import port_host_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    req_t req_in = '0;
    logic r_sel_n = 1'b1;
    logic r_rw_n = 1'b1;
    logic coll_seen = 1'b0;
    logic [10:0] r_addr = '0;
    logic [7:0] r_data = '0;
    logic ready, rv, sel_n, oe_n, rw_n, doe_n, busy_n, flag_n, r_flag_n, pend, coll;
    logic [10:0] addr;
    logic [7:0] dout, din;
    rsp_t rsp;
    int n_fail = 0;
    int num_checks = 0;
    logic [7:0] exp_mem [2048];
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (coll) coll_seen <= 1'b1;
    port_host DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(ready), .rsp_valid_out(rv), .rsp_out(rsp),
        .select_n_out(sel_n), .output_enable_n_out(oe_n), .rw_n_out(rw_n), .addr_out(addr),
        .data_out(dout), .data_oe_n_out(doe_n), .data_in(din), .busy_n_in(busy_n),
        .mailbox_flag_n_in(flag_n), .mailbox_pending_out(pend), .collision_out(coll));
    dpram_model dev (.l_sel_n_in(sel_n), .l_oe_n_in(oe_n), .l_rw_n_in(rw_n), .l_addr_in(addr),
        .l_data_in(dout), .l_data_out(din), .l_busy_n_out(busy_n), .l_flag_n_out(flag_n),
        .r_sel_n_in(r_sel_n), .r_rw_n_in(r_rw_n), .r_addr_in(r_addr), .r_data_in(r_data),
        .r_flag_n_out(r_flag_n));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_req(input op_t op, input logic [10:0] a, input logic [7:0] d);
        int i;
        if (op == OP_WRITE) exp_mem[a] = d;
        @(posedge clk_in);
        #1 req_valid_in = 1'b1;
        req_in = '{op: op, addr: a, wdata: d};
        @(posedge clk_in);
        #1 req_valid_in = 1'b0;
        chk("ready after take", 8'h0, {7'h0, ready});
        for (i = 0; i < 400 && !rv; i++) @(posedge clk_in) #1;
        if (rv !== 1'b1) begin
            chk("rsp_valid", 8'h1, {7'h0, rv});
            print_verdict();
        end else begin
            chk("ready with rsp", 8'h1, {7'h0, ready});
        end
    endtask
    // right writer holds 3 cycles; the model keeps no write without select
    task automatic rput(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1 r_addr = a;
        r_data = d;
        r_rw_n = 1'b0;
        r_sel_n = 1'b0;
        repeat (3) @(posedge clk_in);
        #1 r_sel_n = 1'b1;
        r_rw_n = 1'b1;
        r_data = ~d;
        repeat (6) @(posedge clk_in);
        #1;
    endtask
    initial begin
        logic [10:0] al [8];
        logic [7:0] d;
        logic [7:0] old_byte;
        void'($urandom(42));
        repeat (5) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        chk("idle select", 8'h1, {7'h0, sel_n});
        for (int k = 0; k < 8; k++) begin
            al[k] = (k == 0) ? 11'h000 : (k == 1) ? 11'h7fd : 11'($urandom_range(0, 2045));
            do_req(OP_WRITE, al[k], 8'($urandom));
        end
        for (int k = 0; k < 8; k++) begin
            do_req(OP_READ, al[k], 8'h00);
            chk("read data", exp_mem[al[k]], rsp.rdata);
        end
        $display("test rw done");
        rput(MAILBOX_LEFT_ADDR, 8'h3c);
        chk("pending set", 8'h1, {7'h0, pend});
        do_req(OP_CLEAR, MAILBOX_LEFT_ADDR, 8'h00);
        chk("mailbox byte", 8'h3c, rsp.rdata);
        repeat (6) @(posedge clk_in);
        chk("pending clear", 8'h0, {7'h0, pend});
        do_req(OP_WRITE, MAILBOX_RIGHT_ADDR, 8'ha5);
        chk("right flag set", 8'h0, {7'h0, r_flag_n});
        rput(MAILBOX_RIGHT_ADDR, 8'h5a);
        chk("right flag clear", 8'h1, {7'h0, r_flag_n});
        $display("test mailbox done");
        // right reader holds the byte, so any leaked left write shows in memory
        old_byte = exp_mem[al[2]];
        d = old_byte ^ 8'($urandom_range(1, 255));
        @(posedge clk_in);
        #1 r_addr = al[2];
        r_data = old_byte;
        r_rw_n = 1'b1;
        r_sel_n = 1'b0;
        fork
            begin
                repeat (30) @(posedge clk_in);
                chk("blocked write", old_byte, dev.mem[al[2]]);
                #1 r_sel_n = 1'b1;
            end
            do_req(OP_WRITE, al[2], d);
        join
        chk("busy seen", 8'h1, {7'h0, rsp.busy_seen});
        chk("collision seen", 8'h1, {7'h0, coll_seen});
        do_req(OP_READ, al[2], 8'h00);
        chk("retry data", d, rsp.rdata);
        $display("test busy done");
        print_verdict();
    end
endmodule
`default_nettype wire
